// ### hw/tdrw_map.vh
// register offsets, field positions and reset values of the translation buffer debug read-out
`ifndef TDRW_MAP_VH
`define TDRW_MAP_VH
// ****************************************
// bus geometry
// ****************************************
`define TDRW_ADDR_W 4
`define TDRW_DATA_W 32
`define TDRW_REG_IDX_HI 3
`define TDRW_REG_IDX_LO 2
`define TDRW_OFS_SEL 2'h0
`define TDRW_OFS_DATA 2'h1
`define TDRW_RESP_OKAY 2'h0
`define TDRW_RESP_SLVERR 2'h2
// ****************************************
// select register layout
// ****************************************
`define TDRW_SEL_ENTRY_HI 15
`define TDRW_SEL_ENTRY_LO 4
`define TDRW_SEL_WORD_HI 3
`define TDRW_SEL_WORD_LO 0
`define TDRW_SEL_ENTRY_RST 12'h000
`define TDRW_SEL_WORD_RST 4'h0
// ****************************************
// buffered entry store
// ****************************************
`define TDRW_ENTRY_COUNT 16
`define TDRW_IDX_W 4
`define TDRW_ENTRY_W 55
// ****************************************
// packed entry layout
// ****************************************
`define TDRW_E_PA_HI 27
`define TDRW_E_PA_LO 0
`define TDRW_E_PAX_HI 35
`define TDRW_E_PAX_LO 28
`define TDRW_E_NG 36
`define TDRW_E_S1PS_HI 39
`define TDRW_E_S1PS_LO 37
`define TDRW_E_S2PS_HI 42
`define TDRW_E_S2PS_LO 40
`define TDRW_E_CTX_HI 49
`define TDRW_E_CTX_LO 43
`define TDRW_E_S1LD 50
`define TDRW_E_S1W 51
`define TDRW_E_S2W 52
`define TDRW_E_EN 53
`define TDRW_E_UCM 54
// ****************************************
// word numbers and trailer codes
// ****************************************
`define TDRW_WORD_FIRST 4'h0
`define TDRW_WORD_PHYS 4'h2
`define TDRW_WORD_CTX 4'h3
`define TDRW_WORD_LAST 4'h6
`define TDRW_POS_MIDDLE 2'h0
`define TDRW_POS_ENTRY_FIRST 2'h1
`define TDRW_POS_ENTRY_LAST 2'h2
`define TDRW_POS_BUF_FIRST 2'h3
`define TDRW_FLAG_VALID 1'h0
`define TDRW_FLAG_INVALID 1'h1
`define TDRW_RSVD_BIT 1'h0
`endif

// ### hw/tdrw_entry_mem.v
// store of buffered translation entries with a registered read port
`include "tdrw_map.vh"
module tdrw_entry_mem (
   input wire clk,
   input wire clk_en,
   input wire wr_en,
   input wire [`TDRW_IDX_W-1:0] wr_idx,
   input wire [`TDRW_ENTRY_W-1:0] wr_data,
   input wire rd_en,
   input wire [`TDRW_IDX_W-1:0] rd_idx,
   output reg [`TDRW_ENTRY_W-1:0] rd_data
);
   // ****************************************
   // storage
   // ****************************************
   reg [`TDRW_ENTRY_W-1:0] mem [0:`TDRW_ENTRY_COUNT-1]; // entry contents, not reset

   // write port, a same-cycle read sees the old word
   always @(posedge clk) begin
      if (clk_en && wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   // registered read port
   always @(posedge clk) begin
      if (clk_en && rd_en) begin
         rd_data <= mem[rd_idx];
      end
   end
endmodule // tdrw_entry_mem

// ### hw/tdrw_readout.v
// translation buffer debug read-out: select register, entry store and word formatter behind axi4-lite
`include "tdrw_map.vh"
// What this block does
// - word 2 bits 31:4 hold physical address
// - every word ends with common 4-bit trailer
// - word 3 bit 31 user maintenance enable
// - bit 30 context enable, 26:20 context index
// - bits 29/28 stage 2/1 wide format
// - bit 27 stage 1 long descriptor
// - bits 18:16 stage 2 page size code
// - bits 15:13 stage 1 page size code
// - bit 12 not-global attribute
// - bits 11:4 further physical address bits
// - position code middle/first/last/buffer first
// - pointer flag 0 valid, 1 invalid
// - word flag 0 valid, 1 invalid
module tdrw_readout (
   input wire clk,
   input wire sys_rst,
   input wire clk_en,
   // axi4-lite write address
   input wire [`TDRW_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [`TDRW_DATA_W-1:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [`TDRW_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [`TDRW_DATA_W-1:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // entry fill from the translation logic, same clock
   input wire fill_valid,
   input wire [`TDRW_IDX_W-1:0] fill_index,
   input wire [`TDRW_ENTRY_W-1:0] fill_entry,
   // drop every entry not filled in the same cycle
   input wire flush
);
   // ****************************************
   // read sequencer states
   // ****************************************
   localparam RD_IDLE = 2'b00; // waiting for an address
   localparam RD_MEM = 2'b01; // entry store being read
   localparam RD_RESP = 2'b10; // data offered to master

   // ****************************************
   // declarations
   // ****************************************
   reg [11:0] sel_entry; // entry pointer
   reg [3:0] sel_word; // word pointer
   reg aw_held; // write address captured
   reg w_held; // write data captured
   reg [`TDRW_ADDR_W-1:0] aw_addr; // captured write address
   reg [`TDRW_DATA_W-1:0] w_data; // captured write data
   reg [3:0] w_strb; // captured byte enables
   reg [1:0] rd_state; // read sequencer state
   reg [`TDRW_ADDR_W-1:0] ar_addr; // captured read address
   reg [11:0] snap_entry; // entry pointer seen at read time
   reg [3:0] snap_word; // word pointer seen at read time
   reg snap_valid; // entry validity seen at read time
   reg [`TDRW_ENTRY_COUNT-1:0] entry_valid; // one flag per buffered entry
   wire [`TDRW_ENTRY_W-1:0] mem_rd_data; // entry read from store
   wire aw_hs; // write address taken
   wire w_hs; // write data taken
   wire ar_hs; // read address taken
   wire do_write; // both write halves present
   wire pointer_in_range; // entry pointer names a stored entry
   reg [1:0] entry_word_position; // trailer position field
   reg entry_pointer_invalid; // trailer pointer flag
   reg word_info_invalid; // trailer word flag
   reg [`TDRW_DATA_W-1:0] next_word; // formatted read-out word
   reg [`TDRW_DATA_W-1:0] next_rdata; // read data for response
   reg [1:0] next_rresp; // read response code
   wire user_cache_maint_enable; // entry field
   wire ctx_enable; // entry field
   wire stage2_wide_format; // entry field
   wire stage1_wide_format; // entry field
   wire stage1_long_descriptor; // entry field
   wire [6:0] ctx_index; // entry field
   wire [2:0] s2_page_size; // entry field
   wire [2:0] s1_page_size; // entry field
   wire not_global; // entry field
   wire [7:0] pa_extra; // entry field
   wire [27:0] pa_main; // entry field

   assign aw_hs = s_axi_awvalid & s_axi_awready;
   assign w_hs = s_axi_wvalid & s_axi_wready;
   assign ar_hs = s_axi_arvalid & s_axi_arready;
   assign do_write = aw_held & w_held & ~s_axi_bvalid;

   // ****************************************
   // write channels
   // ****************************************
   // address and data taken in either order, response after both
   always @(posedge clk) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TDRW_RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= {`TDRW_ADDR_W{1'b0}};
         w_data <= {`TDRW_DATA_W{1'b0}};
         w_strb <= 4'h0;
      end else if (clk_en) begin
         // capture address
         if (aw_hs) begin
            aw_addr <= s_axi_awaddr;
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         // capture data
         if (w_hs) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         // issue response
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr[`TDRW_REG_IDX_HI:`TDRW_REG_IDX_LO] == `TDRW_OFS_SEL ||
                aw_addr[`TDRW_REG_IDX_HI:`TDRW_REG_IDX_LO] == `TDRW_OFS_DATA) begin
               s_axi_bresp <= `TDRW_RESP_OKAY;
            end else begin
               s_axi_bresp <= `TDRW_RESP_SLVERR;
            end
         end
         // response taken, reopen both channels
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ****************************************
   // select register
   // ****************************************
   // data word writes fall through untouched
   always @(posedge clk) begin
      if (sys_rst) begin
         sel_entry <= `TDRW_SEL_ENTRY_RST;
         sel_word <= `TDRW_SEL_WORD_RST;
      end else if (clk_en && do_write && aw_addr[`TDRW_REG_IDX_HI:`TDRW_REG_IDX_LO] == `TDRW_OFS_SEL) begin
         // byte 0 holds word pointer and low entry bits
         if (w_strb[0]) begin
            sel_word <= w_data[`TDRW_SEL_WORD_HI:`TDRW_SEL_WORD_LO];
            sel_entry[3:0] <= w_data[7:`TDRW_SEL_ENTRY_LO];
         end
         // byte 1 holds upper entry bits
         if (w_strb[1]) begin
            sel_entry[11:4] <= w_data[`TDRW_SEL_ENTRY_HI:8];
         end
      end
   end

   // ****************************************
   // entry validity flags
   // ****************************************
   // one flag per entry, fill sets, flush clears, fill wins
   genvar gi;
   generate
      for (gi = 0; gi < `TDRW_ENTRY_COUNT; gi = gi + 1) begin : g_valid
         localparam [`TDRW_IDX_W-1:0] SLOT = gi; // slot number of this flag
         always @(posedge clk) begin
            if (sys_rst) begin
               entry_valid[gi] <= 1'b0;
            end else if (clk_en) begin
               if (fill_valid && fill_index == SLOT) begin
                  entry_valid[gi] <= 1'b1;
               end else if (flush) begin
                  entry_valid[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // entry store
   // ****************************************
   tdrw_entry_mem u_mem (
      .clk(clk),
      .clk_en(clk_en),
      .wr_en(fill_valid),
      .wr_idx(fill_index),
      .wr_data(fill_entry),
      .rd_en(ar_hs),
      .rd_idx(sel_entry[`TDRW_IDX_W-1:0]),
      .rd_data(mem_rd_data)
   );

   // ****************************************
   // read sequencer
   // ****************************************
   // selection and entry snapshot taken on the address handshake
   always @(posedge clk) begin
      if (sys_rst) begin
         rd_state <= RD_IDLE;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= {`TDRW_DATA_W{1'b0}};
         s_axi_rresp <= `TDRW_RESP_OKAY;
         ar_addr <= {`TDRW_ADDR_W{1'b0}};
         snap_entry <= `TDRW_SEL_ENTRY_RST;
         snap_word <= `TDRW_SEL_WORD_RST;
         snap_valid <= 1'b0;
      end else if (clk_en) begin
         case (rd_state)
            RD_IDLE: begin
               // take address and freeze the selection
               if (ar_hs) begin
                  ar_addr <= s_axi_araddr;
                  snap_entry <= sel_entry;
                  snap_word <= sel_word;
                  snap_valid <= entry_valid[sel_entry[`TDRW_IDX_W-1:0]];
                  s_axi_arready <= 1'b0;
                  rd_state <= RD_MEM;
               end
            end
            RD_MEM: begin
               // store word ready, present response
               s_axi_rdata <= next_rdata;
               s_axi_rresp <= next_rresp;
               s_axi_rvalid <= 1'b1;
               rd_state <= RD_RESP;
            end
            RD_RESP: begin
               // hold until master takes it
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  s_axi_arready <= 1'b1;
                  rd_state <= RD_IDLE;
               end
            end
            default: begin
               rd_state <= RD_IDLE;
               s_axi_rvalid <= 1'b0;
               s_axi_arready <= 1'b1;
            end
         endcase
      end
   end

   // ****************************************
   // entry field extraction
   // ****************************************
   assign user_cache_maint_enable = mem_rd_data[`TDRW_E_UCM];
   assign ctx_enable = mem_rd_data[`TDRW_E_EN];
   assign stage2_wide_format = mem_rd_data[`TDRW_E_S2W];
   assign stage1_wide_format = mem_rd_data[`TDRW_E_S1W];
   assign stage1_long_descriptor = mem_rd_data[`TDRW_E_S1LD];
   assign ctx_index = mem_rd_data[`TDRW_E_CTX_HI:`TDRW_E_CTX_LO];
   assign s2_page_size = mem_rd_data[`TDRW_E_S2PS_HI:`TDRW_E_S2PS_LO];
   assign s1_page_size = mem_rd_data[`TDRW_E_S1PS_HI:`TDRW_E_S1PS_LO];
   assign not_global = mem_rd_data[`TDRW_E_NG];
   assign pa_extra = mem_rd_data[`TDRW_E_PAX_HI:`TDRW_E_PAX_LO];
   assign pa_main = mem_rd_data[`TDRW_E_PA_HI:`TDRW_E_PA_LO];
   assign pointer_in_range = (snap_entry[11:`TDRW_IDX_W] == 8'h00);

   // ****************************************
   // trailer
   // ****************************************
   // position, pointer and word flags shared by all words
   always @* begin
      // position of the word in the entry and buffer
      if (snap_word == `TDRW_WORD_FIRST) begin
         if (snap_entry == `TDRW_SEL_ENTRY_RST) begin
            entry_word_position = `TDRW_POS_BUF_FIRST;
         end else begin
            entry_word_position = `TDRW_POS_ENTRY_FIRST;
         end
      end else if (snap_word == `TDRW_WORD_LAST) begin
         entry_word_position = `TDRW_POS_ENTRY_LAST;
      end else begin
         entry_word_position = `TDRW_POS_MIDDLE;
      end
      // pointer flag: out of range reads invalid
      entry_pointer_invalid = pointer_in_range ? `TDRW_FLAG_VALID : `TDRW_FLAG_INVALID;
      // word flag: only stored words of a live entry are valid
      if (pointer_in_range && snap_valid &&
          (snap_word == `TDRW_WORD_PHYS || snap_word == `TDRW_WORD_CTX)) begin
         word_info_invalid = `TDRW_FLAG_VALID;
      end else begin
         word_info_invalid = `TDRW_FLAG_INVALID;
      end
   end

   // ****************************************
   // word formatter
   // ****************************************
   // body by word number, trailer always appended
   always @* begin
      case (snap_word)
         `TDRW_WORD_PHYS: begin
            // physical address word
            next_word = {pa_main,
                         entry_word_position, entry_pointer_invalid, word_info_invalid};
         end
         `TDRW_WORD_CTX: begin
            // context and attribute word
            next_word = {user_cache_maint_enable,
                         ctx_enable,
                         stage2_wide_format, stage1_wide_format,
                         stage1_long_descriptor,
                         ctx_index,
                         `TDRW_RSVD_BIT,
                         s2_page_size,
                         s1_page_size,
                         not_global,
                         pa_extra,
                         entry_word_position, entry_pointer_invalid, word_info_invalid};
         end
         default: begin
            // words not held here: trailer only, marked invalid
            next_word = {28'h0000000,
                         entry_word_position, entry_pointer_invalid, word_info_invalid};
         end
      endcase
   end

   // ****************************************
   // read decode
   // ****************************************
   always @* begin
      next_rdata = {`TDRW_DATA_W{1'b0}};
      next_rresp = `TDRW_RESP_OKAY;
      case (ar_addr[`TDRW_REG_IDX_HI:`TDRW_REG_IDX_LO])
         `TDRW_OFS_SEL: begin
            // select register readback
            next_rdata = {16'h0000, snap_entry, snap_word};
         end
         `TDRW_OFS_DATA: begin
            // formatted entry word
            next_rdata = next_word;
         end
         default: begin
            // unmapped
            next_rresp = `TDRW_RESP_SLVERR;
         end
      endcase
   end
endmodule // tdrw_readout

// ### test/tdrw_readout_assertions.sv
// checker for the debug read-out bus and word trailer
`include "tdrw_map.vh"
module tdrw_readout_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [`TDRW_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic [`TDRW_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [`TDRW_DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // register index of the transfers in flight
   // ****************************************
   logic [1:0] rd_sel; // index of the pending read
   logic [1:0] wr_sel; // index of the pending write
   // capture the index at each address take
   always @(posedge clk) begin
      if (s_axi_arvalid && s_axi_arready) rd_sel <= s_axi_araddr[3:2];
      if (s_axi_awvalid && s_axi_awready) wr_sel <= s_axi_awaddr[3:2];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ****************************************
   // properties
   // ****************************************
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##[0:2] s_axi_rvalid)
      else $error("read answer late");
   a_read_stall: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready && !s_axi_wready ##[0:2] s_axi_bvalid)
      else $error("write answer late");
   a_write_resp: assert property (s_axi_bvalid |-> s_axi_bresp == (wr_sel[1] ? `TDRW_RESP_SLVERR : `TDRW_RESP_OKAY))
      else $error("wrong write response");
   a_read_resp: assert property (s_axi_rvalid |-> s_axi_rresp == (rd_sel[1] ? `TDRW_RESP_SLVERR : `TDRW_RESP_OKAY)
      && (!rd_sel[1] || s_axi_rdata == 32'h0))
      else $error("wrong read response");
   a_first_word: assert property (s_axi_rvalid && rd_sel == `TDRW_OFS_DATA && s_axi_rdata[2]
      |-> s_axi_rdata[31:4] == 28'h0 && s_axi_rdata[0])
      else $error("first word not empty and invalid");
   a_last_word: assert property (s_axi_rvalid && rd_sel == `TDRW_OFS_DATA && s_axi_rdata[3:2] == `TDRW_POS_ENTRY_LAST
      |-> s_axi_rdata[31:4] == 28'h0 && s_axi_rdata[0])
      else $error("last word not empty and invalid");
   a_ptr_word: assert property (s_axi_rvalid && rd_sel == `TDRW_OFS_DATA && s_axi_rdata[1] |-> s_axi_rdata[0])
      else $error("bad pointer with valid word");
   a_sel_upper: assert property (s_axi_rvalid && rd_sel == `TDRW_OFS_SEL |-> s_axi_rdata[31:16] == 16'h0)
      else $error("select upper bits not zero");
endmodule // tdrw_readout_chk
bind tdrw_readout tdrw_readout_chk tdrw_readout_chk_i (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid));

// ### test/test_tlb_debug_readout_words.sv
// self-checking bench for the debug read-out words
`include "tdrw_map.vh"
module test_tlb_debug_readout_words;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, fill_index = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic fill_valid = 1'b0, flush = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [54:0] fill_entry = 55'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [54:0] mem [16]; // expected entry contents
   logic vld [16]; // expected entry validity
   int err_total = 0, checks_done = 0;
   tdrw_readout tdrw_readout_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .fill_valid(fill_valid), .fill_index(fill_index), .fill_entry(fill_entry), .flush(flush));
   // free-running clock, 8 ns period
   always #4 clk = ~clk;
   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
      end
   endtask
   task automatic conclude();
      if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // one write, address and data offered together
   task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (1) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
      end
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask
   // one read, data and response taken at the handshake edge
   task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (1) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
      end
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   // load one slot through the fill port
   task automatic fill(input logic [3:0] i, input logic [54:0] e);
      @(posedge clk);
      fill_valid <= 1'b1;
      fill_index <= i;
      fill_entry <= e;
      @(posedge clk);
      fill_valid <= 1'b0;
      mem[i] = e;
      vld[i] = 1'b1;
   endtask
   // entry pattern that differs per slot in every field
   function automatic logic [54:0] pat(input logic [3:0] i);
      return {i[0], ~i[0], i[1], i[2], ~i[1], {i[2:0], i}, i[2:0], ~i[2:0], i[0], ~{i, i}, {7{i}}};
   endfunction
   // expected read-out word from the slot model
   function automatic logic [31:0] exp_word(input logic [11:0] p, input logic [3:0] w);
      logic [54:0] e;
      logic [27:0] b;
      logic [1:0] pos;
      logic ok;
      e = mem[p[3:0]];
      b = 28'h0;
      pos = (w == 4'h0) ? ((p == 12'h0) ? 2'h3 : 2'h1) : ((w == 4'h6) ? 2'h2 : 2'h0);
      ok = (p < 12'h010) && vld[p[3:0]] && (w == 4'h2 || w == 4'h3);
      if (w == 4'h2) b = e[27:0];
      if (w == 4'h3) b = {e[54:50], e[49:43], 1'b0, e[42:40], e[39:37], e[36], e[35:28]};
      return {b, pos, p >= 12'h010, ~ok};
   endfunction
   // select an entry and word, read it back, compare the unmasked bits
   task automatic rd_word(input logic [11:0] p, input logic [3:0] w, input logic [31:0] m);
      wr(4'h0, {16'h0, p, w}, 4'hf, 2'h0);
      rd(4'h4, d, r);
      chk(d & m, exp_word(p, w) & m);
      chk({30'h0, r}, 32'h0);
   endtask
   // ****************************************
   // watchdog
   // ****************************************
   initial begin
      #200000;
      err_total++;
      conclude();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      for (int i = 0; i < 16; i++) vld[i] = 1'b0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      rd(4'h0, d, r);
      chk(d, 32'h0);
      rd_word(12'h0, 4'h0, 32'hffffffff);
      // every page size code in both stages
      for (int i = 0; i < 8; i++) fill(4'(i), pat(4'(i)));
      for (int i = 0; i < 8; i++) begin
         rd_word(12'(i), 4'h2, 32'hffffffff);
         rd_word(12'(i), 4'h3, 32'hffffffff);
      end
      // every word number of one entry
      for (int w = 0; w < 16; w++) rd_word(12'h005, 4'(w), 32'hffffffff);
      // pointer out of range, slot never filled
      rd_word(12'h010, 4'h3, 32'h0000000f);
      rd_word(12'hfff, 4'h2, 32'h0000000f);
      rd_word(12'h00c, 4'h2, 32'h0000000f);
      // data word ignores writes
      rd_word(12'h003, 4'h3, 32'hffffffff);
      wr(4'h4, 32'hffffffff, 4'hf, `TDRW_RESP_OKAY);
      rd(4'h4, d, r);
      chk(d, exp_word(12'h003, 4'h3));
      // unmapped places
      wr(4'h8, 32'h12345678, 4'hf, `TDRW_RESP_SLVERR);
      rd(4'hc, d, r);
      chk(d, 32'h0);
      chk({30'h0, r}, {30'h0, `TDRW_RESP_SLVERR});
      // byte strobe on the select register
      wr(4'h0, 32'h00000123, 4'hf, 2'h0);
      wr(4'h0, 32'hffffffab, 4'h1, 2'h0);
      rd(4'h0, d, r);
      chk(d, 32'h000001ab);
      // refill of the selected slot, then read it back
      rd_word(12'h002, 4'h2, 32'hffffffff);
      fill(4'h2, pat(4'h9));
      rd(4'h4, d, r);
      chk(d, exp_word(12'h002, 4'h2));
      // a fill while the clock enable is low is dropped
      @(posedge clk);
      clk_en <= 1'b0;
      fill_valid <= 1'b1;
      fill_index <= 4'h2;
      fill_entry <= pat(4'h4);
      @(posedge clk);
      clk_en <= 1'b1;
      fill_valid <= 1'b0;
      rd(4'h4, d, r);
      chk(d, exp_word(12'h002, 4'h2));
      // flush while slot 3 refills in the same cycle, the fill wins
      @(posedge clk);
      flush <= 1'b1;
      fill_valid <= 1'b1;
      fill_index <= 4'h3;
      fill_entry <= pat(4'ha);
      @(posedge clk);
      flush <= 1'b0;
      fill_valid <= 1'b0;
      for (int i = 0; i < 16; i++) vld[i] = 1'b0;
      mem[3] = pat(4'ha);
      vld[3] = 1'b1;
      rd(4'h4, d, r);
      chk(d & 32'hf, exp_word(12'h002, 4'h2) & 32'hf);
      rd_word(12'h001, 4'h3, 32'h0000000f);
      rd_word(12'h003, 4'h3, 32'hffffffff);
      conclude();
   end
endmodule // test_tlb_debug_readout_words
